// ==== verilog/afs_params.svh ====
// constants for the automatic function sequencer
`ifndef AFS_PARAMS_SVH
`define AFS_PARAMS_SVH
// clock and timing
`define AFS_CLK_HZ 250000000
`define AFS_SETTLE_MIN_MS 500
`define AFS_SETTLE_TC_MULT 5
`define AFS_MEAS_WIN_S 2
`define AFS_MEAS_MIN_EDGES 3
// register byte offsets
`define AFS_REG_CMD 8'h00
`define AFS_REG_STATUS 8'h04
`define AFS_REG_INPUT_SENSITIVITY_SETTING 8'h08
`define AFS_REG_OFFSET 8'h0c
`define AFS_REG_TC 8'h10
`define AFS_REG_CFG 8'h14
`define AFS_REG_MCYC 8'h18
`define AFS_REG_MPER 8'h1c
// command word fields
`define AFS_CMD_OP_LSB 0
`define AFS_CMD_QRY_BIT 2
`define AFS_CMD_PAR_BIT 3
`define AFS_CMD_Z_BIT 4
// status bits
`define AFS_ST_CMD_ERR 1
`define AFS_ST_NA_ERR 2
`define AFS_ST_RANGE_ERR 3
// config fields and codes
`define AFS_CFG_MODE_LSB 0
`define AFS_CFG_RANGE_LSB 2
`define AFS_CFG_HARM_LSB 4
`define AFS_MODE_EXT 2'h1
`define AFS_HARM_2F 2'h1
`define AFS_HARM_3F 2'h2
// reset values
`define AFS_INPUT_SENSITIVITY_SETTING_RST 5'h0a
`define AFS_TC_RST 32'h0000_0100
// reference ranges in hertz
`define AFS_RNG0_MIN_HZ 64'h1
`define AFS_RNG0_MAX_HZ 64'h64
`define AFS_RNG1_MIN_HZ 64'h64
`define AFS_RNG1_MAX_HZ 64'h2710
`define AFS_RNG2_MIN_HZ 64'h2710
`define AFS_RNG2_MAX_HZ 64'h186a0
`define AFS_RNG3_MIN_HZ 64'h186a0
`define AFS_RNG3_MAX_HZ 64'h30d40
`endif

// ==== verilog/afs_pkg.sv ====
// types for the automatic function sequencer
package afs_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_AG_START, ST_AG_STEP, ST_AG_WAIT, ST_AG_SAMPLE,
        ST_AO_RUN, ST_LA_MEAS, ST_LA_CHECK, ST_LA_ARM
    } afs_fsm_t;
    typedef enum logic [1:0] {OP_GAIN, OP_OFFSET, OP_ASSIST, OP_BAD} afs_op_t;
    typedef struct packed {
        logic [1:0] harm;
        logic [1:0] range;
        logic [1:0] mode;
    } afs_cfg_t;
    typedef struct packed {
        logic locked;
        logic range_err;
        logic na_err;
        logic cmd_err;
    } afs_flags_t;
    typedef struct packed {
        afs_fsm_t fsm;
        logic dir_up;
        logic [4:0] input_sensitivity_setting;
        logic [15:0] ofs;
        logic [31:0] tc;
        afs_cfg_t cfg;
        logic [34:0] settle;
        logic [31:0] cnt;
        logic [31:0] edges;
        logic [31:0] t0;
        logic [31:0] t1;
        logic [31:0] mcyc;
        logic [31:0] mper;
        logic [31:0] tper;
        afs_flags_t flg;
        logic qresp;
        logic halt;
        logic pre;
        logic ref_q;
        logic ack;
        logic [31:0] dat;
    } afs_state_t;
endpackage

// ==== verilog/afs_top.sv ====
// automatic gain, offset and lock-assist sequencer with wishbone registers
// Operation
// R1: no overload at auto-gain start: lower sensitivity one step until overload seen.
// R2: each gain step waits longer of five time constants or 500 ms.
// R3: no overload found: stop at most sensitive setting, 100 nV.
// R4: overload found going down: step back up exactly one setting, finish.
// R5: overload at start: raise sensitivity one step at a time until it clears.
// R6: auto-offset measures output once and writes offset nulling it.
// R7: auto-offset finishes at once, with no settling wait.
// R8: host should start auto-offset only after output has settled.
// R9: lock-assist runs only in external reference mode.
// R10: lock-assist measures frequency over longer of 2 s or two periods.
// R11: check frequency against selected range, scaled by harmonic multiplier.
// R12: valid frequency: halt oscillator and precharge tuning filter.
// R13: arm comparator; release oscillator at next positive zero crossing.
// R14: trailing query bit selects query form of a command.
// R15: braced parameter required for set form, forbidden in query; else rejected.
// R16: bracketed parameter optional in both forms; accepted either way.
// R17: frequency out of range: end without halting or precharging.
`timescale 1ns/100ps
`default_nettype none
`include "afs_params.svh"
module afs_top #(
    parameter int INPUT_SENSITIVITY_SETTING_STEPS = 21,
    parameter int SETTLE_MIN_CYC = `AFS_CLK_HZ / 1000 * `AFS_SETTLE_MIN_MS,
    parameter int MEAS_WIN_CYC = `AFS_CLK_HZ * `AFS_MEAS_WIN_S
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic overload_i,
    input wire logic [15:0] out_meas_i,
    input wire logic ref_cmp_i,
    output logic [4:0] sensitivity_o,
    output logic [15:0] offset_o,
    output logic osc_halt_o,
    output logic precharge_o,
    output logic [31:0] tune_cycles_o,
    output logic [31:0] tune_periods_o
);
    // refuse sizes the 5-bit sensitivity index cannot hold
    if (INPUT_SENSITIVITY_SETTING_STEPS < 2 || INPUT_SENSITIVITY_SETTING_STEPS > 32) begin : g_bad_steps
        $error("INPUT_SENSITIVITY_SETTING_STEPS must lie in 2..32");
    end

    localparam logic [4:0] INPUT_SENSITIVITY_SETTING_MAX = 5'(INPUT_SENSITIVITY_SETTING_STEPS - 1);

    afs_pkg::afs_state_t st_reg;
    afs_pkg::afs_state_t st_next;
    logic ref_rise;
    logic req;
    logic [7:0] adr;
    logic [31:0] wmask;
    logic [34:0] tc_mult;
    logic [34:0] settle_cyc;
    logic [2:0] harm_k;
    logic [63:0] osc_hz_x_cyc;
    logic [63:0] fmin;
    logic [63:0] fmax;
    logic in_range;
    logic busy;
    afs_pkg::afs_op_t op;
    logic is_qry;
    logic has_par;
    logic par_z;
    logic braced;
    logic form_bad;

    // outputs straight from the state register
    assign wb_dat_o = st_reg.dat;
    assign wb_ack_o = st_reg.ack;
    assign sensitivity_o = st_reg.input_sensitivity_setting;
    assign offset_o = st_reg.ofs;
    assign osc_halt_o = st_reg.halt;
    assign precharge_o = st_reg.pre;
    assign tune_cycles_o = st_reg.mcyc;
    assign tune_periods_o = st_reg.tper;

    // settling time: the longer of five time constants or the fixed minimum
    assign tc_mult = {3'h0, st_reg.tc} * 35'(`AFS_SETTLE_TC_MULT); // R2
    assign settle_cyc = (tc_mult > 35'(SETTLE_MIN_CYC)) ? tc_mult : 35'(SETTLE_MIN_CYC); // R2

    // harmonic operation makes the oscillator run at 2f or 3f
    assign harm_k = (st_reg.cfg.harm == `AFS_HARM_2F) ? 3'h2 :
                    (st_reg.cfg.harm == `AFS_HARM_3F) ? 3'h3 : 3'h1; // R11
    // compare f = periods*harm*clk/cycles against limits without a divider
    assign osc_hz_x_cyc = 64'(st_reg.mper) * 64'(harm_k) * 64'(`AFS_CLK_HZ);
    always_comb begin
        unique case (st_reg.cfg.range)
            2'h0: begin
                fmin = `AFS_RNG0_MIN_HZ;
                fmax = `AFS_RNG0_MAX_HZ;
            end
            2'h1: begin
                fmin = `AFS_RNG1_MIN_HZ;
                fmax = `AFS_RNG1_MAX_HZ;
            end
            2'h2: begin
                fmin = `AFS_RNG2_MIN_HZ;
                fmax = `AFS_RNG2_MAX_HZ;
            end
            2'h3: begin
                fmin = `AFS_RNG3_MIN_HZ;
                fmax = `AFS_RNG3_MAX_HZ;
            end
        endcase
    end
    assign in_range = (osc_hz_x_cyc >= fmin * 64'(st_reg.mcyc)) &&
                      (osc_hz_x_cyc <= fmax * 64'(st_reg.mcyc)); // R11

    // bus request and command decode
    assign req = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    assign adr = {wb_adr_i[7:2], 2'h0};
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign busy = (st_reg.fsm != afs_pkg::ST_IDLE);
    assign op = afs_pkg::afs_op_t'(wb_dat_i[`AFS_CMD_OP_LSB +: 2]);
    assign is_qry = wb_dat_i[`AFS_CMD_QRY_BIT]; // R14
    assign has_par = wb_dat_i[`AFS_CMD_PAR_BIT];
    assign par_z = wb_dat_i[`AFS_CMD_Z_BIT];
    assign braced = (op == afs_pkg::OP_OFFSET) || (op == afs_pkg::OP_ASSIST);
    // braced: parameter present exactly in set form; auto-gain takes either
    assign form_bad = (op == afs_pkg::OP_BAD) || (braced && (has_par == is_qry)); // R15 R16
    assign ref_rise = ref_cmp_i & ~st_reg.ref_q;

    // next-state logic: bus first, sequencer after so hardware flag sets win
    always_comb begin
        st_next = st_reg;
        st_next.ack = 1'b0;
        st_next.pre = 1'b0;
        st_next.ref_q = ref_cmp_i;
        if (req) begin
            st_next.ack = 1'b1;
            unique case (adr)
                `AFS_REG_CMD: st_next.dat = {31'h0, st_reg.qresp};
                `AFS_REG_STATUS: st_next.dat = {27'h0, st_reg.flg, busy};
                `AFS_REG_INPUT_SENSITIVITY_SETTING: st_next.dat = {27'h0, st_reg.input_sensitivity_setting};
                `AFS_REG_OFFSET: st_next.dat = {16'h0, st_reg.ofs};
                `AFS_REG_TC: st_next.dat = st_reg.tc;
                `AFS_REG_CFG: st_next.dat = {26'h0, st_reg.cfg};
                `AFS_REG_MCYC: st_next.dat = st_reg.mcyc;
                `AFS_REG_MPER: st_next.dat = st_reg.mper;
                default: st_next.dat = 32'h0;
            endcase
            if (wb_we_i) begin
                unique case (adr)
                    `AFS_REG_CMD: begin
                        if (form_bad) begin
                            st_next.flg.cmd_err = 1'b1; // R15
                        end else if (is_qry) begin
                            // query answers whether that function is running
                            unique case (op)
                                afs_pkg::OP_GAIN: st_next.qresp = (st_reg.fsm inside
                                    {afs_pkg::ST_AG_START, afs_pkg::ST_AG_STEP,
                                     afs_pkg::ST_AG_WAIT, afs_pkg::ST_AG_SAMPLE}); // R14
                                afs_pkg::OP_OFFSET: st_next.qresp =
                                    (st_reg.fsm == afs_pkg::ST_AO_RUN);
                                default: st_next.qresp = (st_reg.fsm inside
                                    {afs_pkg::ST_LA_MEAS, afs_pkg::ST_LA_CHECK,
                                     afs_pkg::ST_LA_ARM});
                            endcase
                        end else if (busy) begin
                            st_next.flg.cmd_err = 1'b1; // one function at a time
                        end else if (op == afs_pkg::OP_GAIN) begin
                            st_next.fsm = afs_pkg::ST_AG_START; // R16
                        end else if (op == afs_pkg::OP_OFFSET) begin
                            if (par_z) begin
                                st_next.fsm = afs_pkg::ST_AO_RUN;
                            end
                        end else if (par_z) begin
                            if (st_reg.cfg.mode != `AFS_MODE_EXT) begin
                                st_next.flg.na_err = 1'b1; // R9
                            end else begin
                                st_next.fsm = afs_pkg::ST_LA_MEAS; // R9
                                st_next.cnt = 32'h0;
                                st_next.edges = 32'h0;
                                st_next.flg.locked = 1'b0;
                            end
                        end
                    end
                    `AFS_REG_STATUS: begin
                        // write one to clear the error flags
                        if (wb_sel_i[0]) begin
                            st_next.flg.cmd_err = st_reg.flg.cmd_err & ~wb_dat_i[`AFS_ST_CMD_ERR];
                            st_next.flg.na_err = st_reg.flg.na_err & ~wb_dat_i[`AFS_ST_NA_ERR];
                            st_next.flg.range_err =
                                st_reg.flg.range_err & ~wb_dat_i[`AFS_ST_RANGE_ERR];
                        end
                    end
                    `AFS_REG_INPUT_SENSITIVITY_SETTING: begin
                        // the sequencer owns the setting while busy
                        if (!busy && wb_sel_i[0] && wb_dat_i[4:0] <= INPUT_SENSITIVITY_SETTING_MAX) begin
                            st_next.input_sensitivity_setting = wb_dat_i[4:0];
                        end
                    end
                    `AFS_REG_OFFSET: begin
                        if (!busy) begin
                            st_next.ofs = (st_reg.ofs & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
                        end
                    end
                    `AFS_REG_TC: st_next.tc = (st_reg.tc & ~wmask) | (wb_dat_i & wmask);
                    `AFS_REG_CFG: begin
                        if (!busy && wb_sel_i[0]) begin
                            st_next.cfg = wb_dat_i[5:0];
                        end
                    end
                    default: ;
                endcase
            end
        end
        unique case (st_reg.fsm)
            afs_pkg::ST_IDLE: ;
            afs_pkg::ST_AG_START: begin
                st_next.dir_up = overload_i;
                if (overload_i ? (st_reg.input_sensitivity_setting == INPUT_SENSITIVITY_SETTING_MAX) : (st_reg.input_sensitivity_setting == 5'h0)) begin
                    st_next.fsm = afs_pkg::ST_IDLE; // R3
                end else begin
                    st_next.fsm = afs_pkg::ST_AG_STEP;
                end
            end
            afs_pkg::ST_AG_STEP: begin
                if (st_reg.dir_up) begin
                    st_next.input_sensitivity_setting = st_reg.input_sensitivity_setting + 5'h1; // R5
                end else begin
                    st_next.input_sensitivity_setting = st_reg.input_sensitivity_setting - 5'h1; // R1
                end
                st_next.settle = settle_cyc; // R2
                st_next.fsm = afs_pkg::ST_AG_WAIT;
            end
            afs_pkg::ST_AG_WAIT: begin
                if (st_reg.settle <= 35'h1) begin
                    st_next.fsm = afs_pkg::ST_AG_SAMPLE; // R2
                end else begin
                    st_next.settle = st_reg.settle - 35'h1;
                end
            end
            afs_pkg::ST_AG_SAMPLE: begin
                if (!st_reg.dir_up && overload_i) begin
                    st_next.input_sensitivity_setting = st_reg.input_sensitivity_setting + 5'h1; // R4
                    st_next.fsm = afs_pkg::ST_IDLE;
                end else if (st_reg.dir_up && !overload_i) begin
                    st_next.fsm = afs_pkg::ST_IDLE; // R5
                end else if (st_reg.dir_up ? (st_reg.input_sensitivity_setting == INPUT_SENSITIVITY_SETTING_MAX) : (st_reg.input_sensitivity_setting == 5'h0)) begin
                    st_next.fsm = afs_pkg::ST_IDLE; // R3
                end else begin
                    st_next.fsm = afs_pkg::ST_AG_STEP; // R1
                end
            end
            afs_pkg::ST_AO_RUN: begin
                // measured after the output filter, so no settling wait
                st_next.ofs = 16'h0 - out_meas_i; // R6
                st_next.fsm = afs_pkg::ST_IDLE; // R7
            end
            afs_pkg::ST_LA_MEAS: begin
                st_next.cnt = st_reg.cnt + 32'h1;
                if (ref_rise) begin
                    st_next.edges = st_reg.edges + 32'h1;
                    st_next.t1 = st_reg.cnt;
                    if (st_reg.edges == 32'h0) begin
                        st_next.t0 = st_reg.cnt;
                    end
                end
                // window: at least the fixed time and two whole input periods
                if (st_reg.cnt >= 32'(MEAS_WIN_CYC) &&
                    st_reg.edges >= 32'(`AFS_MEAS_MIN_EDGES)) begin
                    st_next.mcyc = st_reg.t1 - st_reg.t0; // R10
                    st_next.mper = st_reg.edges - 32'h1; // R10
                    // scaled once here so the tuning output stays a plain flop
                    st_next.tper = 32'(64'(st_reg.edges - 32'h1) * 64'(harm_k)); // R11
                    st_next.fsm = afs_pkg::ST_LA_CHECK;
                end else if (st_reg.cnt == 32'hffff_ffff) begin
                    // no usable reference: give up rather than hang
                    st_next.flg.range_err = 1'b1;
                    st_next.fsm = afs_pkg::ST_IDLE;
                end
            end
            afs_pkg::ST_LA_CHECK: begin
                if (in_range) begin
                    st_next.halt = 1'b1; // R12
                    st_next.pre = 1'b1; // R12
                    st_next.fsm = afs_pkg::ST_LA_ARM;
                end else begin
                    st_next.flg.range_err = 1'b1; // R17
                    st_next.fsm = afs_pkg::ST_IDLE;
                end
            end
            afs_pkg::ST_LA_ARM: begin
                if (ref_rise) begin
                    st_next.halt = 1'b0; // R13
                    st_next.flg.locked = 1'b1;
                    st_next.fsm = afs_pkg::ST_IDLE;
                end
            end
            default: st_next.fsm = afs_pkg::ST_IDLE; // unused enum codes
        endcase
    end

    // single state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
            st_reg.fsm <= afs_pkg::ST_IDLE;
            st_reg.input_sensitivity_setting <= `AFS_INPUT_SENSITIVITY_SETTING_RST;
            st_reg.tc <= `AFS_TC_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_down_step;
        (st_reg.fsm == afs_pkg::ST_AG_STEP && !st_reg.dir_up) |=> st_reg.input_sensitivity_setting == $past(st_reg.input_sensitivity_setting) - 5'h1;
    endproperty
    a_down_step: assert property (p_down_step) else $error("gain step down wrong"); // R1
    property p_settle_load;
        (st_reg.fsm == afs_pkg::ST_AG_STEP) |=> (st_reg.settle == $past(settle_cyc)) && (st_reg.settle >= 35'(SETTLE_MIN_CYC));
    endproperty
    a_settle_load: assert property (p_settle_load) else $error("settle time wrong"); // R2
    property p_floor;
        (st_reg.fsm == afs_pkg::ST_AG_SAMPLE && !st_reg.dir_up && !overload_i && st_reg.input_sensitivity_setting == 5'h0) |=> st_reg.fsm == afs_pkg::ST_IDLE && st_reg.input_sensitivity_setting == 5'h0;
    endproperty
    a_floor: assert property (p_floor) else $error("did not stop at floor"); // R3
    property p_back_one;
        (st_reg.fsm == afs_pkg::ST_AG_SAMPLE && !st_reg.dir_up && overload_i) |=> st_reg.input_sensitivity_setting == $past(st_reg.input_sensitivity_setting) + 5'h1 && st_reg.fsm == afs_pkg::ST_IDLE;
    endproperty
    a_back_one: assert property (p_back_one) else $error("no single step back"); // R4
    property p_up_clear;
        (st_reg.fsm == afs_pkg::ST_AG_SAMPLE && st_reg.dir_up && !overload_i) |=> st_reg.fsm == afs_pkg::ST_IDLE && $stable(st_reg.input_sensitivity_setting);
    endproperty
    a_up_clear: assert property (p_up_clear) else $error("upward search kept going"); // R5
    property p_null;
        (st_reg.fsm == afs_pkg::ST_AO_RUN) |=> offset_o == 16'h0 - $past(out_meas_i) && st_reg.fsm == afs_pkg::ST_IDLE;
    endproperty
    a_null: assert property (p_null) else $error("offset null wrong or slow"); // R6 R7
    property p_ext_only;
        (st_reg.fsm == afs_pkg::ST_IDLE && st_next.fsm == afs_pkg::ST_LA_MEAS) |-> st_reg.cfg.mode == `AFS_MODE_EXT;
    endproperty
    a_ext_only: assert property (p_ext_only) else $error("lock assist outside external mode"); // R9
    property p_halt;
        (st_reg.fsm == afs_pkg::ST_LA_CHECK && in_range) |=> osc_halt_o && precharge_o ##1 !precharge_o;
    endproperty
    a_halt: assert property (p_halt) else $error("halt or precharge missing"); // R12
    property p_release;
        (st_reg.fsm == afs_pkg::ST_LA_ARM && ref_rise) |=> !osc_halt_o && st_reg.fsm == afs_pkg::ST_IDLE;
    endproperty
    a_release: assert property (p_release) else $error("oscillator not released"); // R13
    property p_no_halt;
        (st_reg.fsm == afs_pkg::ST_LA_CHECK && !in_range) |=> !osc_halt_o && !precharge_o;
    endproperty
    a_no_halt: assert property (p_no_halt) else $error("halted out of range"); // R17
    property p_reject;
        (!busy && req && wb_we_i && adr == `AFS_REG_CMD && form_bad) |=> st_reg.flg.cmd_err && $stable(st_reg.fsm);
    endproperty
    a_reject: assert property (p_reject) else $error("bad command form accepted"); // R15
endmodule
`default_nettype wire

// ==== bench/afs_analog_model.sv ====
// stand-in for the analog chain: overload detector and external reference comparator
`timescale 1ns/100ps
`default_nettype none
module afs_analog_model (
    input wire logic clk_i,
    input wire logic [4:0] sensitivity_i,
    input wire logic [4:0] ovl_thr_i,
    input wire logic [31:0] ref_half_i,
    output logic overload_o,
    output logic ref_cmp_o
);
    logic [31:0] ph_reg;
    // overload fires while the gain is above what the signal tolerates
    assign overload_o = (sensitivity_i < ovl_thr_i);
    // square wave reference; stands still low when no period is set
    always_ff @(posedge clk_i) begin
        if (ref_half_i == 32'h0) begin
            ph_reg <= 32'h0;
            ref_cmp_o <= 1'b0;
        end else if (ph_reg >= ref_half_i - 32'h1) begin
            ph_reg <= 32'h0;
            ref_cmp_o <= ~ref_cmp_o;
        end else begin
            ph_reg <= ph_reg + 32'h1;
        end
    end
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench for the automatic function sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, ovl, ref_c, halt, pre, halt_q, ref_q;
    logic halt_seen;
    logic [7:0] wb_adr;
    logic [31:0] wb_wd, wb_rd, tcyc, tper, r, ref_half;
    logic [4:0] input_sensitivity_setting, thr, input_sensitivity_setting_q;
    logic [15:0] meas, ofs;
    int n_mismatch = 0;
    int check_count = 0;
    int since_rise, fall_gap, pre_cnt, gap, gap_min, gap_max, bad_step, nchg;
    afs_top #(.INPUT_SENSITIVITY_SETTING_STEPS(21), .SETTLE_MIN_CYC(20), .MEAS_WIN_CYC(50)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd),
        .wb_ack_o(wb_ack), .overload_i(ovl), .out_meas_i(meas), .ref_cmp_i(ref_c),
        .sensitivity_o(input_sensitivity_setting), .offset_o(ofs), .osc_halt_o(halt), .precharge_o(pre),
        .tune_cycles_o(tcyc), .tune_periods_o(tper));
    afs_analog_model u_model (.clk_i(clk_i), .sensitivity_i(input_sensitivity_setting), .ovl_thr_i(thr),
        .ref_half_i(ref_half), .overload_o(ovl), .ref_cmp_o(ref_c));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // watch step sizes, step spacing, halt and precharge without stalling the bus tasks
    always @(posedge clk_i) begin
        halt_q <= halt;
        ref_q <= ref_c;
        input_sensitivity_setting_q <= input_sensitivity_setting;
        since_rise <= (ref_c === 1'b1 && ref_q === 1'b0) ? 0 : since_rise + 1;
        gap <= (input_sensitivity_setting !== input_sensitivity_setting_q) ? 0 : gap + 1;
        if (halt_q === 1'b1 && halt === 1'b0) fall_gap <= since_rise;
        if (rst_i) begin
            halt_seen <= 1'b0;
            pre_cnt <= 0;
            nchg <= 0;
            gap_min <= 9999;
            gap_max <= 0;
            bad_step <= 0;
        end else begin
            if (halt === 1'b1) halt_seen <= 1'b1;
            if (pre === 1'b1) pre_cnt <= pre_cnt + 1;
            if (input_sensitivity_setting !== input_sensitivity_setting_q) begin
                nchg <= nchg + 1;
                if (nchg > 0 && gap < gap_min) gap_min <= gap;
                if (nchg > 0 && gap > gap_max) gap_max <= gap;
                if (input_sensitivity_setting !== input_sensitivity_setting_q + 5'h1 && input_sensitivity_setting !== input_sensitivity_setting_q - 5'h1) bad_step <= bad_step + 1;
            end
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one classic cycle; request held until ack is sampled, read data taken at that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wd <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        r = wb_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask
    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    // polls the busy bit; a slow run is cut short by the bound, not by luck
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            wb(1'b0, 8'h04, 32'h0);
            n++;
        end while (r[0] !== 1'b0 && n < 10000);
        if (r[0] !== 1'b0) n_mismatch++;
    endtask
    task automatic t_regs();
        do_reset();
        wb(1'b0, 8'h08, 32'h0);
        chk(r, 32'h0a);
        wb(1'b0, 8'h10, 32'h0);
        chk(r, 32'h100);
        wb(1'b0, 8'h20, 32'h0);
        chk(r, 32'h0);
        wb(1'b1, 8'h08, 32'h15);
        wb(1'b0, 8'h08, 32'h0);
        chk(r, 32'h0a);
        wb(1'b1, 8'h08, 32'h03);
        chk(input_sensitivity_setting, 32'h03);
        $display("test regs done");
    endtask
    task automatic t_cmds();
        logic [7:0] c [8] = '{8'h11, 8'h0d, 8'h0e, 8'h13, 8'h04, 8'h0c, 8'h05, 8'h06};
        logic e [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        do_reset();
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, 8'h00, {24'h0, c[i]});
            wb(1'b0, 8'h04, 32'h0);
            chk(r[1], e[i]);
            wb(1'b1, 8'h04, 32'h2);
        end
        wb(1'b0, 8'h00, 32'h0);
        chk(r[0], 1'b0);
        $display("test cmds done");
    endtask
    // measured output is held steady from time zero before any offset run
    task automatic t_offset();
        do_reset();
        wb(1'b1, 8'h00, 32'h09);
        repeat (3) @(posedge clk_i);
        chk(ofs, 16'h0);
        wb(1'b1, 8'h00, 32'h19);
        repeat (3) @(posedge clk_i);
        chk(ofs, 16'hfedd);
        wb(1'b0, 8'h04, 32'h0);
        chk(r[0], 1'b0);
        $display("test offset done");
    endtask
    task automatic t_gain(input logic [4:0] th, input logic [31:0] tc, input logic [7:0] cmd,
                          input logic [4:0] exp, input int s, input logic spaced);
        do_reset();
        thr <= th;
        wb(1'b1, 8'h10, tc);
        wb(1'b1, 8'h00, {24'h0, cmd});
        wb(1'b1, 8'h00, 32'h04);
        wb(1'b0, 8'h00, 32'h0);
        chk(r[0], 1'b1);
        wait_idle();
        chk(input_sensitivity_setting, exp);
        chk(bad_step, 0);
        chk(gap_max <= s + 8, 1'b1);
        if (spaced) chk(gap_min >= s - 1, 1'b1);
        $display("test gain done");
    endtask
    task automatic t_lock(input logic [1:0] mode, input logic [1:0] h, input logic [31:0] half,
                          input logic [2:0] exp);
        int n;
        do_reset();
        ref_half <= half;
        wb(1'b1, 8'h14, {26'h0, h, 2'h3, mode});
        wb(1'b1, 8'h00, 32'h1a);
        wait_idle();
        n = 0;
        while (halt === 1'b1 && n < 20000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20000) n_mismatch++;
        wb(1'b0, 8'h04, 32'h0);
        chk(r[4:2], exp);
        chk(halt_seen, exp[2]);
        chk(pre_cnt, exp[2]);
        if (exp[2]) begin
            chk(fall_gap <= 3, 1'b1);
            chk(tcyc * (h + 1) === tper * half * 2, 1'b1);
            chk(tper >= 2 * (h + 1), 1'b1);
        end
        ref_half <= 32'h0;
        $display("test lock done");
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        rst_i = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h0;
        wb_wd = 32'h0;
        thr = 5'h0;
        ref_half = 32'h0;
        meas = 16'h0123;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_cmds();
        t_offset();
        t_gain(5'd0, 32'd2, 8'h00, 5'd0, 20, 1'b1);
        t_gain(5'd5, 32'd1, 8'h18, 5'd5, 20, 1'b0);
        t_gain(5'd15, 32'd8, 8'h08, 5'd15, 40, 1'b1);
        t_lock(2'h1, 2'h0, 32'd1000, 3'b100);
        t_lock(2'h1, 2'h1, 32'd1000, 3'b010);
        t_lock(2'h1, 2'h1, 32'd2000, 3'b100);
        t_lock(2'h0, 2'h0, 32'd1000, 3'b001);
        report_and_stop();
    end
endmodule
`default_nettype wire
